// ---- design/fsp_pkg.sv ----
// Package with the constants and carrier types of the flash self-programming protection block.
package fsp_pkg;

  // ==========================================================================
  // Geometry
  // ==========================================================================
  localparam int FSP_ADDR_W = 16;
  localparam int FSP_PAGE_W = 6;
  localparam int FSP_BUSY_CNT_W = 16;
  // Default boundary between the concurrent and non-concurrent areas.
  localparam logic [FSP_ADDR_W-1:0] FSP_NC_START_RST = 16'h0C00;
  // Default start of the boot area.
  localparam logic [FSP_ADDR_W-1:0] FSP_BOOT_START_RST = 16'h0E00;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int FSP_CLK_MHZ = 100;
  // Erase or write time of one page, in microseconds.
  localparam int FSP_PROG_TIME_US = 4500;
  localparam int FSP_PROG_CYCLES = FSP_PROG_TIME_US * FSP_CLK_MHZ;

  // ==========================================================================
  // Register map (byte addresses, word-aligned)
  // ==========================================================================
  localparam logic [3:0] FSP_REG_CTRL = 4'h0;
  localparam logic [3:0] FSP_REG_STATUS = 4'h4;
  localparam logic [3:0] FSP_REG_LOCK = 4'h8;
  localparam logic [3:0] FSP_REG_PAGE = 4'hC;

  // CTRL fields.
  localparam int FSP_CTRL_BUSY_CLR = 0;
  localparam int FSP_CTRL_IVEC_BOOT = 1;
  localparam int FSP_CTRL_CHIP_ERASE = 2;
  // STATUS fields.
  localparam int FSP_ST_BUSY = 0;
  localparam int FSP_ST_HALT = 1;
  localparam int FSP_ST_CA_BUSY = 2;
  localparam int FSP_ST_DENIED = 3;
  // LOCK fields: app hi/lo in [1:0], boot hi/lo in [3:2].
  localparam int FSP_LOCK_APP_LO = 0;
  localparam int FSP_LOCK_BOOT_LO = 2;
  localparam logic [1:0] FSP_LOCK_RST = 2'h3;

  // Lock field codes; 1 is unprogrammed, 0 programmed.
  localparam logic [1:0] FSP_LOCK_MODE1 = 2'h3;
  localparam logic [1:0] FSP_LOCK_MODE2 = 2'h2;
  localparam logic [1:0] FSP_LOCK_MODE3 = 2'h0;
  localparam logic [1:0] FSP_LOCK_MODE4 = 2'h1;

  typedef enum logic [1:0] {
    FSP_OP_NONE = 2'b00,
    FSP_OP_ERASE = 2'b01,
    FSP_OP_WRITE = 2'b11,
    FSP_OP_LOCK = 2'b10
  } fsp_op_t;

  typedef enum logic [1:0] {
    FSP_S_IDLE = 2'b00,
    FSP_S_CONC = 2'b01,
    FSP_S_HALT = 2'b11
  } fsp_state_t;

  // A store or load request from the CPU core.
  typedef struct packed {
    logic valid;
    fsp_op_t op;
    logic [FSP_ADDR_W-1:0] pc;
    logic [FSP_ADDR_W-1:0] addr;
    logic [3:0] lock_data;
  } fsp_store_req_t;

  typedef struct packed {
    logic valid;
    logic [FSP_ADDR_W-1:0] pc;
    logic [FSP_ADDR_W-1:0] addr;
  } fsp_load_req_t;

endpackage : fsp_pkg

// ---- design/fsp_protect.sv ----
// Flash self-programming protection: lock checking, stall control and register slave.
//
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
// ============================================================================
// What this block does
// - Concurrent-area page programming keeps non-concurrent code readable and the CPU running.
// - Non-concurrent page programming halts CPU for whole operation; no area readable.
// - Halt or concurrent read chosen from area of the latched target page address.
// - Two independent two-bit lock fields guard application and boot areas.
// - Lock bits programmable by software or programmer; cleared only by chip erase or reset.
// - General write-lock mode 2 never blocks store-program flash programming.
// - General read/write-lock mode 3 never blocks load or store program accesses.
// - Lock bit value 1 means unprogrammed, 0 means programmed.
// - Application field 11 imposes no restriction on application-area accesses.
// - Application field 10 refuses stores to application area, allows loads.
// - Application field 00 refuses stores there and loads of it from boot code.
// - Application field 01 refuses boot-code loads of application area, allows stores.
// - Application modes 3,4 with boot vectors mask interrupts while running application code.
// - Boot field 11 imposes no restriction on boot-area accesses.
// - Boot field 10 refuses stores to boot area, allows loads.
// - Boot field 00 refuses stores there and loads of it from application code.
// - Boot field 01 refuses application-code loads of boot area, allows stores.
// - Boot modes 3,4 with application vectors mask interrupts while running boot code.
// - Store-program starts programming only when executed from boot-area code.
// - Concurrent-area busy flag reads one while that area is blocked.
// ============================================================================
module fsp_protect
  import fsp_pkg::*;
#(
  parameter int PROG_CYCLES = FSP_PROG_CYCLES,
  parameter logic [FSP_ADDR_W-1:0] BOOT_START = FSP_BOOT_START_RST,
  parameter logic [FSP_ADDR_W-1:0] NC_START = FSP_NC_START_RST
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Avalon-MM slave.
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // CPU store and load requests.
  input wire fsp_store_req_t store_req_in,
  input wire fsp_load_req_t load_req_in,
  input wire logic [FSP_ADDR_W-1:0] fetch_pc_in,
  // External serial or parallel programmer lock writes.
  input wire logic prog_lock_we_in,
  input wire logic [3:0] prog_lock_data_in,
  input wire logic prog_chip_erase_in,
  output logic store_ack_out,
  output logic store_denied_out,
  output logic load_ok_out,
  output logic load_denied_out,
  output logic cpu_halt_out,
  output logic concurrent_area_busy_out,
  output logic irq_mask_out,
  output logic flash_prog_start_out,
  output fsp_op_t flash_prog_op_out,
  output logic [FSP_PAGE_W-1:0] flash_prog_page_out
);

  // Returns true when an address lies in the boot area.
  function automatic logic fsp_in_boot(input logic [FSP_ADDR_W-1:0] a);
    return a >= BOOT_START;
  endfunction : fsp_in_boot

  // Store permission for one target: 0 in the field's low bit blocks stores.
  function automatic logic fsp_store_ok(input logic [1:0] field);
    return field[0];
  endfunction : fsp_store_ok

  // Load permission across areas: modes 3 and 4 refuse it, both have the high bit programmed.
  function automatic logic fsp_cross_load_ok(input logic [1:0] field);
    return !(field == FSP_LOCK_MODE3 || field == FSP_LOCK_MODE4);
  endfunction : fsp_cross_load_ok

  // ==========================================================================
  // State
  // ==========================================================================
  fsp_state_t state_r;
  logic [FSP_BUSY_CNT_W+4-1:0] cnt_r;
  logic [1:0] app_lock_field_r;
  logic [1:0] boot_lock_field_r;
  logic ca_busy_r;
  logic ivec_boot_r;
  logic denied_r;
  logic [FSP_PAGE_W-1:0] page_r;
  logic [31:0] rdata_r;
  logic rd_done_r;

  logic bus_wr;
  logic busy;
  logic store_from_boot;
  logic target_boot;
  logic store_allowed;
  logic store_go;
  logic lock_go;
  logic ld_from_boot;
  logic ld_target_boot;
  logic load_allowed;
  logic chip_erase;
  logic [3:0] lock_set;

  assign busy = (state_r != FSP_S_IDLE);
  assign bus_wr = avs_write_in && avs_byteenable_in[0];
  assign chip_erase = prog_chip_erase_in ||
                      (bus_wr && avs_address_in == FSP_REG_CTRL && avs_writedata_in[FSP_CTRL_CHIP_ERASE]);

  // ==========================================================================
  // Store-program checking
  // ==========================================================================
  // Only the lock fields decide; the general memory lock bits have no input here at all.
  always_comb begin
    store_from_boot = fsp_in_boot(store_req_in.pc);
    target_boot = fsp_in_boot(store_req_in.addr);
    if (target_boot) begin
      store_allowed = fsp_store_ok(boot_lock_field_r);
    end else begin
      store_allowed = fsp_store_ok(app_lock_field_r);
    end
  end

  // A request waits while a page operation runs; the core sees no acknowledge until then.
  assign store_go = store_req_in.valid && !busy && store_from_boot &&
                    (store_req_in.op == FSP_OP_ERASE || store_req_in.op == FSP_OP_WRITE) &&
                    store_allowed;
  assign lock_go = store_req_in.valid && !busy && store_from_boot && store_req_in.op == FSP_OP_LOCK;
  assign store_ack_out = store_req_in.valid && !busy;
  assign store_denied_out = store_ack_out && !store_go && !lock_go;

  // ==========================================================================
  // Load-program checking
  // ==========================================================================
  always_comb begin
    ld_from_boot = fsp_in_boot(load_req_in.pc);
    ld_target_boot = fsp_in_boot(load_req_in.addr);
    if (ld_target_boot && !ld_from_boot) begin
      load_allowed = fsp_cross_load_ok(boot_lock_field_r);
    end else if (!ld_target_boot && ld_from_boot) begin
      load_allowed = fsp_cross_load_ok(app_lock_field_r);
    end else begin
      load_allowed = 1'b1;
    end
    // Concurrent-area data cannot be read while that area is blocked.
    if (ca_busy_r && load_req_in.addr < NC_START) begin
      load_allowed = 1'b0;
    end
  end

  // Loads are stalled by the halt output during non-concurrent programming.
  assign load_ok_out = load_req_in.valid && !cpu_halt_out && load_allowed;
  assign load_denied_out = load_req_in.valid && !cpu_halt_out && !load_allowed;

  // ==========================================================================
  // Lock fields
  // ==========================================================================
  // Programming can only clear bits; a one written leaves the bit as it stands.
  assign lock_set = (lock_go ? store_req_in.lock_data : 4'hF) & (prog_lock_we_in ? prog_lock_data_in : 4'hF);

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      app_lock_field_r <= FSP_LOCK_RST;
      boot_lock_field_r <= FSP_LOCK_RST;
    end else if (chip_erase) begin
      app_lock_field_r <= FSP_LOCK_RST;
      boot_lock_field_r <= FSP_LOCK_RST;
    end else begin
      app_lock_field_r <= app_lock_field_r & lock_set[FSP_LOCK_APP_LO +: 2];
      boot_lock_field_r <= boot_lock_field_r & lock_set[FSP_LOCK_BOOT_LO +: 2];
    end
  end

  // ==========================================================================
  // Programming sequencer
  // ==========================================================================
  // Target area taken from the address at the start, which the page latch then holds.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      state_r <= FSP_S_IDLE;
      cnt_r <= '0;
      page_r <= '0;
    end else begin
      unique case (state_r)
        FSP_S_IDLE: begin
          if (store_go) begin
            page_r <= store_req_in.addr[FSP_ADDR_W-1 -: FSP_PAGE_W];
            cnt_r <= '0;
            if (store_req_in.addr >= NC_START) begin
              state_r <= FSP_S_HALT;
            end else begin
              state_r <= FSP_S_CONC;
            end
          end
        end
        FSP_S_CONC, FSP_S_HALT: begin
          if (cnt_r == (FSP_BUSY_CNT_W+4)'(PROG_CYCLES - 1)) begin
            state_r <= FSP_S_IDLE;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        default: state_r <= FSP_S_IDLE;
      endcase
    end
  end

  assign cpu_halt_out = (state_r == FSP_S_HALT);

  // Start pulse and page toward the flash array.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      flash_prog_start_out <= 1'b0;
      flash_prog_op_out <= FSP_OP_NONE;
    end else begin
      flash_prog_start_out <= store_go;
      if (store_go) begin
        flash_prog_op_out <= store_req_in.op;
      end
    end
  end
  assign flash_prog_page_out = page_r;

  // ==========================================================================
  // Concurrent-area busy and refusal flags
  // ==========================================================================
  // The busy flag survives the end of programming until software clears it; a new start wins.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ca_busy_r <= 1'b0;
    end else if (store_go && store_req_in.addr < NC_START) begin
      ca_busy_r <= 1'b1;
    end else if (bus_wr && avs_address_in == FSP_REG_CTRL && avs_writedata_in[FSP_CTRL_BUSY_CLR] &&
                 state_r != FSP_S_CONC) begin
      ca_busy_r <= 1'b0;
    end
  end
  assign concurrent_area_busy_out = ca_busy_r;

  // Sticky refusal flag; a new refusal wins over the clear by write of one.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      denied_r <= 1'b0;
    end else if (store_denied_out || load_denied_out) begin
      denied_r <= 1'b1;
    end else if (bus_wr && avs_address_in == FSP_REG_STATUS && avs_writedata_in[FSP_ST_DENIED]) begin
      denied_r <= 1'b0;
    end
  end

  // Interrupt vector placement selected by software.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ivec_boot_r <= 1'b0;
    end else if (bus_wr && avs_address_in == FSP_REG_CTRL) begin
      ivec_boot_r <= avs_writedata_in[FSP_CTRL_IVEC_BOOT];
    end
  end

  // ==========================================================================
  // Interrupt masking
  // ==========================================================================
  // Vectors in the other area would be fetched through a locked read path.
  always_comb begin
    irq_mask_out = 1'b0;
    if (ivec_boot_r && !fsp_in_boot(fetch_pc_in) && !fsp_cross_load_ok(app_lock_field_r)) begin
      irq_mask_out = 1'b1;
    end
    if (!ivec_boot_r && fsp_in_boot(fetch_pc_in) && !fsp_cross_load_ok(boot_lock_field_r)) begin
      irq_mask_out = 1'b1;
    end
  end

  // ==========================================================================
  // Avalon-MM slave
  // ==========================================================================
  // Writes finish at once; reads take one wait cycle so read data come from a flip-flop.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rd_done_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      rd_done_r <= avs_read_in && !rd_done_r;
      if (avs_read_in && !rd_done_r) begin
        unique case (avs_address_in)
          FSP_REG_CTRL: rdata_r <= {30'h0000_0000, ivec_boot_r, 1'b0};
          FSP_REG_STATUS: rdata_r <= {28'h000_0000, denied_r, ca_busy_r, cpu_halt_out, busy};
          FSP_REG_LOCK: rdata_r <= {28'h000_0000, boot_lock_field_r, app_lock_field_r};
          FSP_REG_PAGE: rdata_r <= {26'h000_0000, page_r};
          default: rdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign avs_waitrequest_out = avs_read_in && !rd_done_r;
  assign avs_readdata_out = rdata_r;

endmodule : fsp_protect

// ---- dv/fsp_protect_monitor.sv ----
// Assertion checker for the flash self-programming protection block.
`timescale 1ns/1ps
// ==========================================================================
// Checker
// ==========================================================================
module fsp_protect_monitor
  import fsp_pkg::*;
#(
  parameter int PROG_CYCLES = FSP_PROG_CYCLES,
  parameter logic [FSP_ADDR_W-1:0] BOOT_START = FSP_BOOT_START_RST,
  parameter logic [FSP_ADDR_W-1:0] NC_START = FSP_NC_START_RST
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire fsp_store_req_t store_req_in,
  input wire fsp_load_req_t load_req_in,
  input wire logic [FSP_ADDR_W-1:0] fetch_pc_in,
  input wire logic prog_lock_we_in,
  input wire logic [3:0] prog_lock_data_in,
  input wire logic prog_chip_erase_in,
  input wire logic store_ack_out,
  input wire logic store_denied_out,
  input wire logic load_ok_out,
  input wire logic load_denied_out,
  input wire logic cpu_halt_out,
  input wire logic concurrent_area_busy_out,
  input wire logic irq_mask_out,
  input wire logic flash_prog_start_out,
  input wire fsp_op_t flash_prog_op_out,
  input wire logic [FSP_PAGE_W-1:0] flash_prog_page_out
);
  logic [3:0] lk_r;
  logic ivec_r;
  logic [15:0] halt_run_r;
  wire logic ctl_wr = avs_write_in && avs_address_in == FSP_REG_CTRL && avs_byteenable_in[0];
  wire logic go = store_ack_out && !store_denied_out;
  wire logic [FSP_PAGE_W-1:0] page_w = store_req_in.addr[15:10];
  wire logic tgt_boot = store_req_in.addr >= BOOT_START;
  wire logic ld_boot = load_req_in.addr >= BOOT_START;

  // Shadow of the lock fields; programming can only clear bits, so an AND is enough.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      lk_r <= 4'hF;
      ivec_r <= 1'b0;
      halt_run_r <= 16'h0000;
    end else begin
      lk_r <= (prog_chip_erase_in || (ctl_wr && avs_writedata_in[2])) ? 4'hF :
        lk_r & (prog_lock_we_in ? prog_lock_data_in : 4'hF) &
        ((go && store_req_in.op == FSP_OP_LOCK) ? store_req_in.lock_data : 4'hF);
      ivec_r <= ctl_wr ? avs_writedata_in[1] : ivec_r;
      halt_run_r <= cpu_halt_out ? halt_run_r + 16'h0001 : 16'h0000;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_prog_go;
    go && store_req_in.op inside {FSP_OP_ERASE, FSP_OP_WRITE};
  endsequence

  property p_nc_halt;
    s_prog_go ##0 (store_req_in.addr >= NC_START) |=> cpu_halt_out && flash_prog_start_out;
  endproperty
  a_nc_halt: assert property (p_nc_halt) else $error("no halt after non-concurrent start");
  property p_conc;
    s_prog_go ##0 (store_req_in.addr < NC_START) |=> (!cpu_halt_out && concurrent_area_busy_out) [*8];
  endproperty
  a_conc: assert property (p_conc) else $error("concurrent programming halted or not busy");
  property p_halt_len;
    $fell(cpu_halt_out) |-> halt_run_r == PROG_CYCLES;
  endproperty
  a_halt_len: assert property (p_halt_len) else $error("halt length wrong");
  property p_page;
    s_prog_go |=> flash_prog_page_out == $past(page_w) && flash_prog_op_out == $past(store_req_in.op);
  endproperty
  a_page: assert property (p_page) else $error("latched page wrong");
  property p_pc_boot;
    store_ack_out && store_req_in.pc < BOOT_START |-> store_denied_out;
  endproperty
  a_pc_boot: assert property (p_pc_boot) else $error("store from application code accepted");
  property p_store_lock;
    store_ack_out && store_req_in.pc >= BOOT_START && store_req_in.op inside {FSP_OP_ERASE, FSP_OP_WRITE}
      |-> store_denied_out == !(tgt_boot ? lk_r[2] : lk_r[0]);
  endproperty
  a_store_lock: assert property (p_store_lock) else $error("store lock decision wrong");
  property p_load_cross;
    load_req_in.valid && !cpu_halt_out && !concurrent_area_busy_out && (load_req_in.pc >= BOOT_START) != ld_boot
      |-> load_denied_out == !(ld_boot ? lk_r[3] : lk_r[1]) && load_ok_out != load_denied_out;
  endproperty
  a_load_cross: assert property (p_load_cross) else $error("load lock decision wrong");
  property p_ca_load;
    load_req_in.valid && concurrent_area_busy_out && load_req_in.addr < NC_START |-> !load_ok_out;
  endproperty
  a_ca_load: assert property (p_ca_load) else $error("blocked area was readable");
  property p_halt_quiet;
    cpu_halt_out |-> !load_ok_out && !store_ack_out;
  endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("access served while halted");
  property p_irq;
    irq_mask_out == (fetch_pc_in >= BOOT_START ? !lk_r[3] && !ivec_r : !lk_r[1] && ivec_r);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt mask wrong");
endmodule : fsp_protect_monitor

bind fsp_protect fsp_protect_monitor #(.PROG_CYCLES(PROG_CYCLES), .BOOT_START(BOOT_START), .NC_START(NC_START))
  u_mon (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .avs_address_in(avs_address_in),
  .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
  .store_req_in(store_req_in), .load_req_in(load_req_in), .fetch_pc_in(fetch_pc_in),
  .prog_lock_we_in(prog_lock_we_in), .prog_lock_data_in(prog_lock_data_in), .prog_chip_erase_in(prog_chip_erase_in),
  .store_ack_out(store_ack_out), .store_denied_out(store_denied_out), .load_ok_out(load_ok_out),
  .load_denied_out(load_denied_out), .cpu_halt_out(cpu_halt_out), .concurrent_area_busy_out(concurrent_area_busy_out),
  .irq_mask_out(irq_mask_out), .flash_prog_start_out(flash_prog_start_out), .flash_prog_op_out(flash_prog_op_out),
  .flash_prog_page_out(flash_prog_page_out));

// ---- dv/fsp_cpu_model.sv ----
// Behavioural CPU core that issues store requests and holds each until it is taken.
`timescale 1ns/1ps
// ==========================================================================
// CPU partner
// ==========================================================================
module fsp_cpu_model
  import fsp_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic go_in,
  input wire fsp_store_req_t cmd_in,
  input wire logic store_ack_in,
  output fsp_store_req_t store_req_out
);
  // A request waits out a busy block; once taken its lines flip so stale values never look valid.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      store_req_out <= '0;
    end else if (store_req_out.valid && store_ack_in) begin
      store_req_out <= ~store_req_out;
    end else if (go_in && !store_req_out.valid) begin
      store_req_out <= cmd_in;
    end
  end
endmodule : fsp_cpu_model

// ---- dv/fsp_protect_tb.sv ----
// Self-checking testbench for the flash self-programming protection block.
`timescale 1ns/1ps
// ==========================================================================
// Testbench
// ==========================================================================
module fsp_protect_tb
  import fsp_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [3:0] avs_address_in = 4'h0;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0000_0000;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out, store_ack_out, store_denied_out, load_ok_out, load_denied_out, go = 1'b0;
  fsp_load_req_t load_req_in = '0;
  fsp_store_req_t cmd = '0;
  fsp_store_req_t store_req_in;
  logic [15:0] fetch_pc_in = 16'h0000, a, b;
  logic prog_lock_we_in = 1'b0, prog_chip_erase_in = 1'b0;
  logic [3:0] prog_lock_data_in = 4'hF, lk = 4'hF;
  logic [1:0] code;
  logic [1:0] modes [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
  logic [31:0] exp_q [$];
  int errors = 0, n_checks = 0, seed = 83, cyc = 0;

  always #5 clk_sys_in = ~clk_sys_in;

  fsp_protect #(.PROG_CYCLES(8)) DUT (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hF), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .store_req_in(store_req_in), .load_req_in(load_req_in),
    .fetch_pc_in(fetch_pc_in), .prog_lock_we_in(prog_lock_we_in), .prog_lock_data_in(prog_lock_data_in),
    .prog_chip_erase_in(prog_chip_erase_in), .store_ack_out(store_ack_out), .store_denied_out(store_denied_out),
    .load_ok_out(load_ok_out), .load_denied_out(load_denied_out), .cpu_halt_out(), .concurrent_area_busy_out(),
    .irq_mask_out(), .flash_prog_start_out(), .flash_prog_op_out(), .flash_prog_page_out());
  fsp_cpu_model u_cpu (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .go_in(go), .cmd_in(cmd),
    .store_ack_in(store_ack_out), .store_req_out(store_req_in));

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  // Avalon master: the request stands until waitrequest is seen low at an edge.
  task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] d);
    @(posedge clk_sys_in);
    avs_address_in <= ad;
    avs_writedata_in <= d;
    avs_read_in <= !wr;
    avs_write_in <= wr;
    do @(posedge clk_sys_in); while (avs_waitrequest_out !== 1'b0);
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask : bus

  task automatic rd(input logic [3:0] ad, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, ad, 32'h0000_0000);
  endtask : rd

  task automatic st(input fsp_op_t op, input logic [15:0] pc, ad, input logic [3:0] ld, input logic dn);
    exp_q.push_back({31'h0, dn});
    @(posedge clk_sys_in);
    cmd <= '{1'b1, op, pc, ad, ld};
    go <= 1'b1;
    @(posedge clk_sys_in);
    go <= 1'b0;
    do @(posedge clk_sys_in); while (store_ack_out !== 1'b1);
  endtask : st

  task automatic ld(input logic [15:0] pc, ad, input logic ok, dn);
    exp_q.push_back({30'h0, ok, dn});
    @(posedge clk_sys_in);
    load_req_in <= '{1'b1, pc, ad};
    @(posedge clk_sys_in);
    load_req_in <= '{1'b0, ~pc, ~ad};
  endtask : ld

  // Programmer pins: chip erase or a lock write, one cycle each.
  task automatic prog(input logic er, input logic [3:0] d);
    @(posedge clk_sys_in);
    prog_chip_erase_in <= er;
    prog_lock_we_in <= !er;
    prog_lock_data_in <= d;
    @(posedge clk_sys_in);
    prog_chip_erase_in <= 1'b0;
    prog_lock_we_in <= 1'b0;
  endtask : prog

  function automatic logic sdeny(input fsp_op_t op, input logic [15:0] pc, ad);
    if (pc < FSP_BOOT_START_RST || op == FSP_OP_NONE) return 1'b1;
    return ad >= FSP_BOOT_START_RST ? !lk[2] : !lk[0];
  endfunction : sdeny

  // Result watcher: each answer at the ports takes the oldest expectation.
  always @(posedge clk_sys_in) begin
    if (store_ack_out === 1'b1) chk({31'h0, store_denied_out}, exp_q.pop_front());
    if (avs_read_in && avs_waitrequest_out === 1'b0) chk(avs_readdata_out, exp_q.pop_front());
    if (load_req_in.valid) chk({30'h0, load_ok_out, load_denied_out}, exp_q.pop_front());
  end

  // Hang guard; the whole run needs well under a thousand cycles.
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      print_verdict();
    end
  end

  // Main sequence: every lock code on both fields, then concurrent and halting programming.
  initial begin
    repeat (20) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    rd(FSP_REG_LOCK, 32'h0000_000F);
    rd(4'h2, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      code = modes[i];
      if (i[0]) bus(1'b1, FSP_REG_CTRL, 32'h0000_0004);
      else prog(1'b1, 4'hF);
      lk = 4'hF;
      bus(1'b1, FSP_REG_CTRL, {30'h0, i[1], 1'b0});
      if (i[0]) prog(1'b0, {code, code});
      else st(FSP_OP_LOCK, 16'h0E20, 16'h0000, {code, code}, 1'b0);
      lk = {code, code};
      rd(FSP_REG_LOCK, {28'h0, lk});
      a = 16'($random(seed)) & 16'h0BFF;
      b = 16'h0E00 | (16'($random(seed)) & 16'h01FF);
      fetch_pc_in <= b;
      st(FSP_OP_WRITE, 16'h0E10, a, 4'hF, sdeny(FSP_OP_WRITE, 16'h0E10, a));
      st(FSP_OP_ERASE, 16'h0F00, b, 4'hF, sdeny(FSP_OP_ERASE, 16'h0F00, b));
      st(FSP_OP_ERASE, a, a, 4'hF, 1'b1);
      st(FSP_OP_NONE, 16'h0E10, b, 4'hF, 1'b1);
      repeat (12) @(posedge clk_sys_in);
      bus(1'b1, FSP_REG_CTRL, {30'h0, i[1], 1'b1});
      fetch_pc_in <= a;
      ld(16'h0E10, a, lk[1], !lk[1]);
      ld(a, b, lk[3], !lk[3]);
      ld(a, a ^ 16'h0001, 1'b1, 1'b0);
    end
    prog(1'b1, 4'hF);
    lk = 4'hF;
    bus(1'b1, FSP_REG_STATUS, 32'h0000_0008);
    st(FSP_OP_ERASE, 16'h0E40, 16'h0400, 4'hF, 1'b0);
    rd(FSP_REG_STATUS, 32'h0000_0005);
    ld(16'h0C10, 16'h0C20, 1'b1, 1'b0);
    ld(16'h0C10, 16'h0100, 1'b0, 1'b1);
    repeat (12) @(posedge clk_sys_in);
    rd(FSP_REG_STATUS, 32'h0000_000C);
    bus(1'b1, FSP_REG_CTRL, 32'h0000_0001);
    rd(FSP_REG_STATUS, 32'h0000_0008);
    st(FSP_OP_WRITE, 16'h0E40, 16'h0C40, 4'hF, 1'b0);
    ld(16'h0E40, 16'h0E80, 1'b0, 1'b0);
    repeat (12) @(posedge clk_sys_in);
    print_verdict();
  end
endmodule : fsp_protect_tb
